//--- core/cmj_ctrl.sv
// control logic of a 10 Mb/s coaxial attachment unit: transmit gating,
// receive gating, collision signalling, jabber and heartbeat test
// assumes all inputs synchronous to CLK_IN; analog squelch, comparators
// and the tap driver itself are outside and report through plain levels
`timescale 1ns/1ps
`include "cmj_cfg.svh"

module cmj_ctrl #(
  parameter logic [`CMJ_CNT_W-1:0] JAB_TICKS =
    `CMJ_CNT_W'(`CMJ_JAB_TICKS),
  parameter logic [`CMJ_CNT_W-1:0] UNJAB_TICKS =
    `CMJ_CNT_W'(`CMJ_UNJAB_TICKS)
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic POWER_GOOD_IN,
  input wire logic DO_ACTIVE_IN,
  input wire logic DO_DATA_IN,
  input wire logic TAP_FAULT_IN,
  input wire logic DRIVER_SUPPLY_RETURN_REMOVED_IN,
  input wire logic HEARTBEAT_TEST_STRAP_IN,
  input wire logic TAP_RECEIVE_CARRIER_IN,
  input wire logic TAP_RECEIVE_DATA_IN,
  input wire logic COLLISION_LEVEL_IN,
  output logic TAP_DRIVE_LINE_OUT,
  output logic TAP_DRIVE_EN_OUT,
  output logic DI_OUT,
  output logic CI_OUT,
  output logic COLLISION_OUT,
  output logic JABBER_OUT
);

  logic osc_q;
  logic tick;
  logic [`CMJ_NOISE_W-1:0] noise_run_q;
  logic do_valid_q;
  logic strap_q;
  logic sqe_enabled;
  cmj_pkg::cmj_jab_t jab_q;
  cmj_pkg::cmj_jab_t jab_d;
  logic [`CMJ_CNT_W-1:0] jab_cnt_q;
  logic [`CMJ_CNT_W-1:0] jab_cnt_d;
  logic drive_en_d;
  logic drive_en_q;
  logic tx_end;
  cmj_pkg::cmj_sqe_t sqe_q;
  cmj_pkg::cmj_sqe_t sqe_d;
  logic [`CMJ_SQE_W-1:0] sqe_cnt_q;
  logic [`CMJ_SQE_W-1:0] sqe_cnt_d;
  logic jabber_active;
  logic collision_q;
  logic ci_req;
  logic ci_hold;
  logic ci_q;
  logic carrier_q;
  logic di_hold;
  logic di_q;
  logic tap_data_q;
  logic jabber_q;
  logic coll_req;
  logic sqe_req;
  logic sup_req;

  // collision oscillator: half the system clock, one cycle is one bit
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      osc_q <= 1'h0;
    end else begin
      osc_q <= ~osc_q;
    end
  end

  // one tick per oscillator cycle paces the jabber, unjab and heartbeat timers
  assign tick = osc_q;

  // a high pulse on DO must persist this many cycles to count as activity
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      noise_run_q <= '0;
      do_valid_q <= 1'h0;
    end else if (!DO_ACTIVE_IN) begin
      noise_run_q <= '0;
      do_valid_q <= 1'h0;
    end else begin
      if (noise_run_q != {`CMJ_NOISE_W{1'h1}}) begin
        noise_run_q <= noise_run_q + `CMJ_NOISE_W'(1);
      end
      do_valid_q <= (noise_run_q >=
        `CMJ_NOISE_W'(`CMJ_NOISE_CYC - 1));
    end
  end

  // strap is meant to be static; sampling it keeps reset free of pins
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      strap_q <= ~`CMJ_STRAP_ON;
    end else begin
      strap_q <= HEARTBEAT_TEST_STRAP_IN;
    end
  end

  assign sqe_enabled = (strap_q == `CMJ_STRAP_ON);

  // jabber controller
  always_comb begin
    jab_d = jab_q;
    jab_cnt_d = jab_cnt_q;
    case (jab_q)
      cmj_pkg::JAB_IDLE: begin
        jab_cnt_d = '0;
        if (TAP_FAULT_IN) begin
          jab_d = cmj_pkg::JAB_INHIBIT;
        end else if (do_valid_q) begin
          jab_d = cmj_pkg::JAB_TX;
        end
      end
      cmj_pkg::JAB_TX: begin
        if (TAP_FAULT_IN) begin
          jab_d = cmj_pkg::JAB_INHIBIT;
          jab_cnt_d = '0;
        end else if (!do_valid_q) begin
          jab_d = cmj_pkg::JAB_IDLE;
          jab_cnt_d = '0;
        end else if (tick) begin
          // the limit tick itself still drives; only the next one exceeds
          if (jab_cnt_q >= JAB_TICKS) begin
            jab_d = cmj_pkg::JAB_INHIBIT;
            jab_cnt_d = '0;
          end else begin
            jab_cnt_d = jab_cnt_q + `CMJ_CNT_W'(1);
          end
        end
      end
      cmj_pkg::JAB_INHIBIT: begin
        jab_cnt_d = '0;
        if (!do_valid_q && !TAP_FAULT_IN) begin
          jab_d = cmj_pkg::JAB_UNJAB;
        end
      end
      cmj_pkg::JAB_UNJAB: begin
        // any activity or fault restarts the whole unjab interval
        if (do_valid_q || TAP_FAULT_IN) begin
          jab_d = cmj_pkg::JAB_INHIBIT;
          jab_cnt_d = '0;
        end else if (tick) begin
          if (jab_cnt_q >= UNJAB_TICKS - `CMJ_CNT_W'(1)) begin
            jab_d = cmj_pkg::JAB_IDLE;
            jab_cnt_d = '0;
          end else begin
            jab_cnt_d = jab_cnt_q + `CMJ_CNT_W'(1);
          end
        end
      end
      default: begin
        jab_d = cmj_pkg::JAB_IDLE;
        jab_cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      jab_q <= cmj_pkg::JAB_IDLE;
      jab_cnt_q <= '0;
    end else begin
      jab_q <= jab_d;
      jab_cnt_q <= jab_cnt_d;
    end
  end

  assign jabber_active = (jab_q == cmj_pkg::JAB_INHIBIT) ||
    (jab_q == cmj_pkg::JAB_UNJAB);

  // status pin from a flop: it must not glitch while the state moves
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      jabber_q <= 1'h0;
    end else begin
      jabber_q <= (jab_d == cmj_pkg::JAB_INHIBIT) ||
        (jab_d == cmj_pkg::JAB_UNJAB);
    end
  end

  // the driver runs only on filtered activity with power and no jabber
  assign drive_en_d = do_valid_q && (jab_d == cmj_pkg::JAB_TX) &&
    POWER_GOOD_IN &&
    !DRIVER_SUPPLY_RETURN_REMOVED_IN;

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      drive_en_q <= 1'h0;
    end else begin
      drive_en_q <= drive_en_d;
    end
  end

  // data held low while the driver is off: no stray edge reaches the tap
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      tap_data_q <= 1'h0;
    end else begin
      tap_data_q <= drive_en_d ? DO_DATA_IN : 1'h0;
    end
  end

  // a transmission ends when the driver drops after being on
  assign tx_end = drive_en_q && !drive_en_d;

  // heartbeat test sequencer
  always_comb begin
    sqe_d = sqe_q;
    sqe_cnt_d = sqe_cnt_q;
    case (sqe_q)
      cmj_pkg::SQE_IDLE: begin
        sqe_cnt_d = '0;
        if (tx_end && sqe_enabled) begin
          sqe_d = cmj_pkg::SQE_WAIT;
        end
      end
      cmj_pkg::SQE_WAIT: begin
        if (drive_en_d) begin
          sqe_d = cmj_pkg::SQE_IDLE;
          sqe_cnt_d = '0;
        end else if (tick) begin
          if (sqe_cnt_q >= `CMJ_SQE_W'(`CMJ_SQE_DLY_BITS - 1)) begin
            sqe_d = cmj_pkg::SQE_BURST;
            sqe_cnt_d = '0;
          end else begin
            sqe_cnt_d = sqe_cnt_q + `CMJ_SQE_W'(1);
          end
        end
      end
      cmj_pkg::SQE_BURST: begin
        if (tick) begin
          if (sqe_cnt_q >= `CMJ_SQE_W'(`CMJ_SQE_LEN_BITS - 1)) begin
            sqe_d = cmj_pkg::SQE_IDLE;
            sqe_cnt_d = '0;
          end else begin
            sqe_cnt_d = sqe_cnt_q + `CMJ_SQE_W'(1);
          end
        end
      end
      default: begin
        sqe_d = cmj_pkg::SQE_IDLE;
        sqe_cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sqe_q <= cmj_pkg::SQE_IDLE;
      sqe_cnt_q <= '0;
    end else begin
      sqe_q <= sqe_d;
      sqe_cnt_q <= sqe_cnt_d;
    end
  end

  // the level comparator sees other stations whether or not we transmit
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      collision_q <= 1'h0;
    end else begin
      collision_q <= COLLISION_LEVEL_IN;
    end
  end

  // causes are kept apart: any one of them gates the oscillator onto CI
  assign coll_req = collision_q;
  assign sqe_req = (sqe_q == cmj_pkg::SQE_BURST);
  // supply removal bypasses the jabber states, so CI follows the external
  // disable time plus the end-of-burst hold and not the unjab interval
  assign sup_req = DRIVER_SUPPLY_RETURN_REMOVED_IN;
  assign ci_req = coll_req ||
    sqe_req ||
    jabber_active ||
    sup_req;

  cmj_tail u_ci_tail (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .active_in(ci_req),
    .hold_out(ci_hold)
  );

  // idle returns immediately after the hold, well inside twenty bits
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ci_q <= 1'h0;
    end else if (ci_req) begin
      ci_q <= osc_q;
    end else begin
      ci_q <= ci_hold;
    end
  end

  // receive path: two register stages from carrier to DI, far inside five bit times
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      carrier_q <= 1'h0;
    end else begin
      carrier_q <= TAP_RECEIVE_CARRIER_IN;
    end
  end

  cmj_tail u_di_tail (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .active_in(carrier_q),
    .hold_out(di_hold)
  );

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      di_q <= 1'h0;
    end else if (carrier_q) begin
      di_q <= TAP_RECEIVE_DATA_IN;
    end else begin
      di_q <= di_hold;
    end
  end

  assign TAP_DRIVE_LINE_OUT = tap_data_q;
  assign TAP_DRIVE_EN_OUT = drive_en_q;
  assign DI_OUT = di_q;
  assign CI_OUT = ci_q;
  assign COLLISION_OUT = collision_q;
  assign JABBER_OUT = jabber_q;

endmodule : cmj_ctrl

//--- core/cmj_tail.sv
// end-of-burst hold: keeps a line high for a fixed time after activity
// assumes the timing header and a single synchronous clock
`timescale 1ns/1ps
`include "cmj_cfg.svh"

module cmj_tail (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic active_in,
  output logic hold_out
);

  logic active_q;
  logic [`CMJ_TAIL_W-1:0] cnt_q;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_q <= 1'h0;
    end else begin
      active_q <= active_in;
    end
  end

  // the hold is dropped at once by new activity, the owner drives then
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= '0;
    end else if (active_in) begin
      cnt_q <= '0;
    end else if (active_q) begin
      cnt_q <= `CMJ_TAIL_W'(`CMJ_TAIL_CYC - 1);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - `CMJ_TAIL_W'(1);
    end
  end

  // active_q covers the first hold cycle, so the line never dips low
  assign hold_out = active_q || (cnt_q != '0);

endmodule : cmj_tail

//--- pkg/cmj_cfg.svh
// timing constants of the coax attachment unit control logic
// assumes a 20 MHz system clock and a 10 MHz collision oscillator
`ifndef CMJ_CFG_SVH
`define CMJ_CFG_SVH

// clock and bit time
`define CMJ_CLK_NS 50
`define CMJ_BIT_NS 100
`define CMJ_CLK_PER_BIT (`CMJ_BIT_NS / `CMJ_CLK_NS)

// transmit noise filter: least pulse width, rounded up to whole cycles
`define CMJ_NOISE_NS 7
`define CMJ_NOISE_CYC ((`CMJ_NOISE_NS + `CMJ_CLK_NS - 1) / `CMJ_CLK_NS)
`define CMJ_NOISE_W 4

// jabber and unjab intervals, counted in oscillator cycles
`define CMJ_JAB_MS 26
`define CMJ_UNJAB_MS 400
`define CMJ_JAB_TICKS (`CMJ_JAB_MS * 1000000 / `CMJ_BIT_NS)
`define CMJ_UNJAB_TICKS (`CMJ_UNJAB_MS * 1000000 / `CMJ_BIT_NS)
`define CMJ_CNT_W 23

// heartbeat test delay and length in bit times
`define CMJ_SQE_DLY_BITS 8
`define CMJ_SQE_LEN_BITS 8
`define CMJ_SQE_W 4

// end-of-burst high hold in bit times, expressed in clocks
`define CMJ_TAIL_BITS 2
`define CMJ_TAIL_CYC (`CMJ_TAIL_BITS * `CMJ_CLK_PER_BIT)
`define CMJ_TAIL_W 4

// strap level that enables the heartbeat test (tied to negative supply)
`define CMJ_STRAP_ON 1'h0

`endif

//--- pkg/cmj_pkg.sv
// types of the coax attachment unit control logic
// assumes nothing beyond the timing header
package cmj_pkg;

  typedef enum logic [1:0] {
    JAB_IDLE,
    JAB_TX,
    JAB_INHIBIT,
    JAB_UNJAB
  } cmj_jab_t;

  typedef enum logic [1:0] {
    SQE_IDLE,
    SQE_WAIT,
    SQE_BURST
  } cmj_sqe_t;

endpackage : cmj_pkg

//--- verif/cmj_ctrl_assertions.sv
// port assertions of the coax attachment control block
// assumes one clock domain and an active-low async reset
`timescale 1ns/1ps
module cmj_ctrl_assertions #(
  parameter logic [22:0] JAB_TICKS = 23'h14,
  parameter logic [22:0] UNJAB_TICKS = 23'h1e
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic POWER_GOOD_IN,
  input wire logic DO_ACTIVE_IN,
  input wire logic DO_DATA_IN,
  input wire logic DRIVER_SUPPLY_RETURN_REMOVED_IN,
  input wire logic TAP_RECEIVE_CARRIER_IN,
  input wire logic COLLISION_LEVEL_IN,
  input wire logic TAP_DRIVE_LINE_OUT,
  input wire logic TAP_DRIVE_EN_OUT,
  input wire logic DI_OUT,
  input wire logic CI_OUT,
  input wire logic JABBER_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  sequence s_di_hold; DI_OUT [*2]; endsequence
  sequence s_rx_quiet; !TAP_RECEIVE_CARRIER_IN [*8]; endsequence
  property p_pwr; !POWER_GOOD_IN [*2] |-> !TAP_DRIVE_EN_OUT; endproperty
  a_pwr: assert property (p_pwr) else $error("drive at low power");
  property p_off; !DO_ACTIVE_IN [*3] |=> !TAP_DRIVE_EN_OUT; endproperty
  a_off: assert property (p_off) else $error("drive without DO");
  property p_line; TAP_DRIVE_EN_OUT |-> TAP_DRIVE_LINE_OUT == $past(DO_DATA_IN);
  endproperty
  a_line: assert property (p_line) else $error("line data wrong");
  property p_coll_ci; COLLISION_LEVEL_IN [*5] |-> CI_OUT != $past(CI_OUT);
  endproperty
  a_coll_ci: assert property (p_coll_ci) else $error("no ci osc");
  property p_jab_ci; JABBER_OUT [*3] |-> CI_OUT != $past(CI_OUT); endproperty
  a_jab_ci: assert property (p_jab_ci) else $error("no jabber ci");
  property p_sup; DRIVER_SUPPLY_RETURN_REMOVED_IN [*4] |->
    !TAP_DRIVE_EN_OUT && CI_OUT != $past(CI_OUT); endproperty
  a_sup: assert property (p_sup) else $error("supply removal");
  property p_di_hold; $fell(TAP_RECEIVE_CARRIER_IN) ##1
    !TAP_RECEIVE_CARRIER_IN [*2] |=> s_di_hold; endproperty
  a_di_hold: assert property (p_di_hold) else $error("di tail low");
  property p_di_idle; $fell(TAP_RECEIVE_CARRIER_IN) ##1 s_rx_quiet |=>
    !DI_OUT; endproperty
  a_di_idle: assert property (p_di_idle) else $error("di not idle");
  property p_di_first; $fell(TAP_RECEIVE_CARRIER_IN) |-> ##2 DI_OUT;
  endproperty
  a_di_first: assert property (p_di_first) else $error("di tail gap");
  property p_jab_off; JABBER_OUT |-> !TAP_DRIVE_EN_OUT; endproperty
  a_jab_off: assert property (p_jab_off) else $error("drive in jabber");
endmodule : cmj_ctrl_assertions
bind cmj_ctrl cmj_ctrl_assertions #(.JAB_TICKS(JAB_TICKS),
  .UNJAB_TICKS(UNJAB_TICKS)) cmj_ctrl_assertions_i (.*);

//--- verif/cmj_dte_model.sv
// dte side model: frames of transmit activity on the DO pair
// assumes the bench calls send for one frame at a time
`timescale 1ns/1ps
module cmj_dte_model (
  input wire logic clk_in,
  output logic do_active_out = 1'h0,
  output logic do_data_out = 1'h0
);
  // data keeps changing when idle so a stale bit never looks valid
  always @(posedge clk_in) do_data_out <= ~do_data_out;
  task automatic send(input int n);
    @(posedge clk_in) do_active_out <= 1'h1;
    repeat (n) @(posedge clk_in);
    do_active_out <= 1'h0;
  endtask : send
endmodule : cmj_dte_model

//--- verif/tb_cmj_ctrl.sv
// bench of the coax attachment control block, one task per scenario
// assumes short jabber and unjab counts set at the instance
`timescale 1ns/1ps
module tb_cmj_ctrl;
  logic clk = 1'h0, rst_n = 1'h0, pg = 1'h1, strap = 1'h1, flt = 1'h0;
  logic sup = 1'h0, car = 1'h0, rxd = 1'h0, col = 1'h0;
  logic doa, dod, line, en, di, ci, cout, jab;
  int n_fail = 0, num_checks = 0, cyc = 0;
  cmj_dte_model cmj_dte_model_i (.clk_in(clk), .do_active_out(doa),
    .do_data_out(dod));
  cmj_ctrl #(.JAB_TICKS(23'h14), .UNJAB_TICKS(23'h1e)) cmj_ctrl_i (
    .CLK_IN(clk), .RESETN_IN(rst_n), .POWER_GOOD_IN(pg),
    .DO_ACTIVE_IN(doa), .DO_DATA_IN(dod), .TAP_FAULT_IN(flt),
    .DRIVER_SUPPLY_RETURN_REMOVED_IN(sup), .HEARTBEAT_TEST_STRAP_IN(strap),
    .TAP_RECEIVE_CARRIER_IN(car), .TAP_RECEIVE_DATA_IN(rxd),
    .COLLISION_LEVEL_IN(col), .TAP_DRIVE_LINE_OUT(line),
    .TAP_DRIVE_EN_OUT(en), .DI_OUT(di), .CI_OUT(ci), .COLLISION_OUT(cout),
    .JABBER_OUT(jab));
  task automatic chk(input string n, input logic [7:0] e, s);
    num_checks++;
    if (e !== s) begin
      n_fail++;
      $display("mismatch %s exp %0h got %0h", n, e, s);
    end
  endtask : chk
  // sampling on the falling edge keeps reads clear of the update edge
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic ci_hi(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(negedge clk);
      h += (ci === 1'h1);
    end
  endtask : ci_hi
  task automatic go(input int n);
    fork
      cmj_dte_model_i.send(n);
    join_none
  endtask : go
  task automatic t_tx(input logic s, input logic b);
    int h;
    @(posedge clk);
    rst_n <= 1'h0;
    strap <= s;
    @(posedge clk);
    rst_n <= 1'h1;
    go(10);
    wt(3);
    chk("en_early", 0, en);
    wt(1);
    chk("en_on", 1, en);
    chk("line", !dod, line);
    wt(11);
    chk("en_off", 0, en);
    chk("line_off", 0, line);
    ci_hi(12, h);
    chk("hb_gap", 0, h);
    ci_hi(30, h);
    chk("hb_burst", b, h > 0);
    wt(20);
    chk("ci_idle", 0, ci);
  endtask : t_tx
  task automatic t_cancel;
    int h;
    go(10);
    wt(16);
    go(10);
    ci_hi(26, h);
    chk("hb_cancel", 0, h);
    ci_hi(30, h);
    chk("hb_resched", 1, h > 0);
  endtask : t_cancel
  task automatic t_pwr;
    go(20);
    wt(6);
    chk("en_pre", 1, en);
    @(posedge clk);
    pg <= 1'h0;
    wt(3);
    chk("en_lowpwr", 0, en);
    @(posedge clk);
    pg <= 1'h1;
    wt(60);
  endtask : t_pwr
  task automatic t_col;
    int h;
    go(40);
    wt(6);
    @(posedge clk);
    col <= 1'h1;
    wt(4);
    chk("coll", 1, cout);
    ci_hi(8, h);
    chk("ci_osc", 4, h);
    @(posedge clk);
    col <= 1'h0;
    wt(4);
    chk("ci_tail", 1, ci);
    wt(12);
    chk("ci_end", 0, ci);
    wt(80);
  endtask : t_col
  task automatic t_sup;
    int h;
    go(20);
    wt(6);
    @(posedge clk);
    sup <= 1'h1;
    wt(3);
    chk("en_sup", 0, en);
    ci_hi(8, h);
    chk("ci_sup", 4, h);
    @(posedge clk);
    sup <= 1'h0;
    wt(60);
  endtask : t_sup
  task automatic t_jab;
    go(150);
    wt(40);
    chk("jab_pre", 1, en);
    wt(14);
    chk("jab_off", 0, en);
    chk("jab_on", 1, jab);
    wt(116);
    // a fault in mid unjab must restart the idle count
    @(posedge clk);
    flt <= 1'h1;
    repeat (2) @(posedge clk);
    flt <= 1'h0;
    wt(50);
    chk("unjab_wait", 1, jab);
    wt(30);
    chk("unjab_done", 0, jab);
  endtask : t_jab
  task automatic t_rx;
    @(posedge clk);
    car <= 1'h1;
    rxd <= 1'h1;
    wt(5);
    chk("di_fwd", 1, di);
    @(posedge clk);
    rxd <= 1'h0;
    wt(5);
    chk("di_data", 0, di);
    @(posedge clk);
    car <= 1'h0;
    repeat (3) @(posedge clk) rxd <= ~rxd;
    wt(1);
    chk("di_hold", 1, di);
    repeat (30) @(posedge clk) rxd <= ~rxd;
    wt(1);
    chk("di_idle", 0, di);
  endtask : t_rx
  task automatic tally_and_finish;
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial forever #25 clk = ~clk;
  // the scenarios need about 800 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    t_tx(1'h1, 1'h0);
    t_tx(1'h0, 1'h1);
    t_cancel;
    t_pwr;
    t_col;
    t_sup;
    t_jab;
    t_rx;
    tally_and_finish;
  end
endmodule : tb_cmj_ctrl
